/* design/ppp_pkg.sv */
// constants for the parallel printer output port
// assumes a host processor bus with byte strobes and full addresses
package ppp_pkg;
  localparam int          ADDR_W        = 24;
  localparam logic [23:0] ADDR_DATA     = 24'hfe6000;
  localparam logic [23:0] ADDR_STROBE   = 24'hfe6002;
  localparam logic [23:0] ADDR_RESTART  = 24'hfe6004;
  localparam logic [23:0] ADDR_ACK_CLR  = 24'hfe6006;
  localparam int          ST_ACK        = 0;
  localparam int          ST_BUSY       = 1;
  localparam int          ST_PAPER      = 2;
  localparam int          ST_SELECT     = 3;
  localparam int          ST_FAULT      = 4;
  localparam int          ST_SER_B      = 5;
  localparam int          ST_SER_A      = 6;
  localparam int          STAT_IN_W     = 7;
  localparam logic [7:0]  RD_ZERO       = 8'h00;
endpackage : ppp_pkg

/* design/ppp_sync.sv */
// two-stage synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module ppp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppp_sync_st_t;

  ppp_sync_st_t st;
  ppp_sync_st_t next_st;

  // s1 feeds only s2, nothing else looks at it
  always_comb
  begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  // reset to all ones so an idle active-low ack gives no false edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st <= '1;
    else
      st <= next_st;
  end

  assign dout = st.s2;
endmodule : ppp_sync
`default_nettype wire

/* design/ppp_port.sv */
// parallel printer output port: data latch, strobe, restart, ack latch
// host side: byte writes to the latch, status reads, control by access
// control lines are set by a write and cleared by a read of one address,
// so the written or read data of a control access carries no meaning
// printer side: eight data lines, strobe and restart out, five status in
// two serial line status bits ride along on the status read
// ack falling edge sets a latched interrupt for the interrupt port
// assumes single-cycle bus strobes from the host processor on clk
// assumes all printer and serial pins are asynchronous to clk
// assumes the host keeps strobe width and ack handshake in software
`timescale 1ns/1ps
`default_nettype none
module ppp_port
  import ppp_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [ppp_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  input  wire logic [7:0]                bus_wdata,
  output logic      [7:0]                bus_rdata,
  output logic      [7:0]                out_data,
  output logic                           strobe_n,
  output logic                           restart_n,
  output logic                           ack_irq,
  input  wire logic                      ack_n,
  input  wire logic                      busy,
  input  wire logic                      paper_out,
  input  wire logic                      online_select,
  input  wire logic                      fault_n,
  input  wire logic                      serial_b_line_status,
  input  wire logic                      serial_a_line_status
);
  import ppp_pkg::*;

  // whole state in one word; the latch shares it with the control bits
  typedef struct packed
  {
    logic [7:0] latch;
    logic       strobe_on;
    logic       restart_on;
    logic       ack_latched;
    logic       ack_prev;
    logic [7:0] rdata;
  } ppp_state_t;

  ppp_state_t st;
  ppp_state_t next_st;
  logic [STAT_IN_W-1:0] pins_raw;
  logic [STAT_IN_W-1:0] pins;
  logic                 ack_fall;
  // decoded accesses, one per address and direction
  logic                 wr_data;
  logic                 rd_status;
  logic                 wr_strobe;
  logic                 rd_strobe;
  logic                 wr_restart;
  logic                 rd_restart;
  logic                 rd_ack_clr;
  logic                 wr_ack_clr;
  logic                 rd_no_data;

  // exact compare of the full byte address, so no port aliases another
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  // all status pins pass two flops before use
  // the two serial line bits share the status read with the printer lines
  // fault and ack stay active low as they arrive
  assign pins_raw[ST_ACK]    = ack_n;
  assign pins_raw[ST_BUSY]   = busy;
  assign pins_raw[ST_PAPER]  = paper_out;
  assign pins_raw[ST_SELECT] = online_select;
  assign pins_raw[ST_FAULT]  = fault_n;
  assign pins_raw[ST_SER_B]  = serial_b_line_status;
  assign pins_raw[ST_SER_A]  = serial_a_line_status;

  // one synchroniser for all seven; reset value one matches the idle active-low ack and fault pins
  ppp_sync #(
    .W(STAT_IN_W)
  ) u_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  (pins_raw),
    .dout (pins)
  );

  // edge taken on the synchronised level only
  assign ack_fall = st.ack_prev & ~pins[ST_ACK];

  // address decode; reads and writes of one address are told apart here
  assign wr_data     = bus_wr && hit(bus_addr, ADDR_DATA);
  assign rd_status   = bus_rd && hit(bus_addr, ADDR_DATA);
  assign wr_strobe   = bus_wr && hit(bus_addr, ADDR_STROBE);
  assign rd_strobe   = bus_rd && hit(bus_addr, ADDR_STROBE);
  assign wr_restart  = bus_wr && hit(bus_addr, ADDR_RESTART);
  assign rd_restart  = bus_rd && hit(bus_addr, ADDR_RESTART);
  assign rd_ack_clr  = bus_rd && hit(bus_addr, ADDR_ACK_CLR);
  assign wr_ack_clr  = bus_wr && hit(bus_addr, ADDR_ACK_CLR);
  // reads of anything but status return zero
  assign rd_no_data  = !rd_status;

  // next-state: bus decode, ack latch and board reset
  always_comb
  begin
    next_st          = st;
    next_st.ack_prev = pins[ST_ACK];
    next_st.rdata    = RD_ZERO;
    // the latch has no reset of its own; only a write changes it
    if (wr_data)
    begin
      next_st.latch = bus_wdata;
    end
    // write turns the strobe on, a read turns it off; the read wins a tie
    if (wr_strobe)
    begin
      next_st.strobe_on = 1'b1;
    end
    if (rd_strobe)
    begin
      next_st.strobe_on = 1'b0;
    end
    // restart follows the same set-by-write, clear-by-read pattern
    if (wr_restart)
    begin
      next_st.restart_on = 1'b1;
    end
    if (rd_restart)
    begin
      next_st.restart_on = 1'b0;
    end
    // any read here clears; a write to this address is ignored
    if (rd_ack_clr)
    begin
      next_st.ack_latched = 1'b0;
    end
    // set after clear so a coinciding edge survives
    if (ack_fall)
    begin
      next_st.ack_latched = 1'b1;
    end
    // status is the synced pin image; the ack bit is only a short pulse
    if (rd_status)
    begin
      // top bit undefined, read as zero
      next_st.rdata = {1'b0, pins};
    end
    // board reset drops control and the ack latch but keeps the data byte,
    // so a reset in mid-job does not lose the character on the lines
    if (!rst_n)
    begin
      next_st.strobe_on   = 1'b0;
      next_st.restart_on  = 1'b0;
      next_st.ack_latched = 1'b0;
      next_st.ack_prev    = 1'b1;
      next_st.rdata       = RD_ZERO;
      next_st.latch       = st.latch;
    end
  end

  // one register for the whole state; reset is folded into next_st above
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  // outputs; the strobe and restart lines are active low at the pins, data and ack_irq are not
  // strobe and restart are inverted once, here, so state stays active high
  assign out_data  = st.latch;
  assign strobe_n  = ~st.strobe_on;
  assign restart_n = ~st.restart_on;
  assign ack_irq   = st.ack_latched;
  assign bus_rdata = st.rdata;

  // access effects and the ack latch
  a_strobe_set: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && hit(bus_addr, ADDR_STROBE) && !bus_rd |=> !strobe_n)
    else $error("strobe not asserted after write");
  a_strobe_clr: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && hit(bus_addr, ADDR_STROBE) |=> strobe_n)
    else $error("strobe not dropped after read");
  a_restart_ctl: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && hit(bus_addr, ADDR_RESTART) |=> restart_n)
    else $error("restart not dropped after read");
  a_latch_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && hit(bus_addr, ADDR_DATA) |=> out_data == $past(bus_wdata))
    else $error("data latch not updated");
  a_ack_set: assert property (@(posedge clk) disable iff (!rst_n)
    ack_fall |=> ack_irq)
    else $error("ack edge not latched");
  a_ack_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ack_fall && bus_rd && hit(bus_addr, ADDR_ACK_CLR) |=> ack_irq)
    else $error("clear beat ack edge");
  a_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !ack_fall && bus_rd && hit(bus_addr, ADDR_ACK_CLR) |=> !ack_irq)
    else $error("ack not cleared");
  a_reset_out: assert property (@(posedge clk)
    !rst_n |=> strobe_n && restart_n)
    else $error("strobe or restart active after reset");
  a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && hit(bus_addr, ADDR_DATA) |=> bus_rdata[ST_BUSY] == $past(pins[ST_BUSY]))
    else $error("status busy bit wrong");
  a_single_edge: assert property (@(posedge clk) disable iff (!rst_n)
    ack_fall |=> !ack_fall)
    else $error("ack edge seen twice");

  // strobe and restart move only on their own accesses or reset
  a_restart_set: assert property (@(posedge clk) disable iff (!rst_n)
    wr_restart && !rd_restart |=> !restart_n)
    else $error("restart not asserted after write");

  a_strobe_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_strobe && !rd_strobe |=> $stable(strobe_n))
    else $error("strobe moved without access");

  a_restart_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_restart && !rd_restart |=> $stable(restart_n))
    else $error("restart moved without access");

  a_strobe_race: assert property (@(posedge clk) disable iff (!rst_n)
    wr_strobe && rd_strobe |=> strobe_n)
    else $error("strobe read lost to write");

  a_restart_race: assert property (@(posedge clk) disable iff (!rst_n)
    wr_restart && rd_restart |=> restart_n)
    else $error("restart read lost to write");

  a_strobe_on: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(strobe_n) |-> $past(wr_strobe))
    else $error("strobe on without write");

  a_strobe_off: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strobe_n) |-> $past(rd_strobe) || !$past(rst_n))
    else $error("strobe off without read");

  a_restart_on: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(restart_n) |-> $past(wr_restart))
    else $error("restart on without write");

  a_restart_off: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(restart_n) |-> $past(rd_restart) || !$past(rst_n))
    else $error("restart off without read");

  // ack latch: set only by a synced edge, cleared only by a read or reset
  a_ack_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_ack_clr && !ack_fall |=> $stable(ack_irq))
    else $error("ack latch moved without cause");

  a_clr_wr_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ack_clr && !rd_ack_clr && ack_irq |=> ack_irq)
    else $error("write cleared ack latch");

  a_ack_edge_only: assert property (@(posedge clk) disable iff (!rst_n)
    !ack_fall && !ack_irq |=> !ack_irq)
    else $error("ack latch set without edge");

  a_ack_needs_high: assert property (@(posedge clk) disable iff (!rst_n)
    ack_fall |-> $past(pins[ST_ACK]))
    else $error("ack edge without prior high");

  a_ack_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ack_irq) |-> $past(ack_fall))
    else $error("ack latch rose without edge");

  a_ack_drop: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(ack_irq) |-> $past(rd_ack_clr) || !$past(rst_n))
    else $error("ack latch fell without read");

  // read data and the data latch
  a_status_word: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> bus_rdata == {1'b0, $past(pins)})
    else $error("status word wrong");

  a_status_ack: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> bus_rdata[ST_ACK] == $past(pins[ST_ACK]))
    else $error("status ack bit wrong");

  a_status_top: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> !bus_rdata[STAT_IN_W])
    else $error("status top bit not zero");

  a_status_fault: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> bus_rdata[ST_FAULT] == $past(pins[ST_FAULT]))
    else $error("status fault bit wrong");

  a_rdata_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd_no_data |=> bus_rdata == RD_ZERO)
    else $error("read data not zero");

  a_latch_stable: assert property (@(posedge clk)
    (rst_n && wr_data) ##1 !wr_data |=> $stable(out_data))
    else $error("data latch changed without write");

  a_rdata_reset: assert property (@(posedge clk)
    !rst_n |=> bus_rdata == RD_ZERO && !ack_irq)
    else $error("read data or ack set after reset");
endmodule : ppp_port
`default_nettype wire

/* verification/ppp_printer.sv */
// printer model: answers each strobe with busy and one ack pulse
// assumes strobe_n comes from the port, registered on clk
`timescale 1ns/1ps
`default_nettype none
module ppp_printer (
  input  wire logic clk,
  input  wire logic strobe_n,
  output logic      ack_n,
  output logic      busy
);
  // busy from strobe on until ack ends; ack only after strobe is off
  initial
  begin
    ack_n = 1'b1;
    busy  = 1'b0;
    forever
    begin
      @(negedge strobe_n);
      #1 busy = 1'b1;
      @(posedge strobe_n);
      repeat (10) @(posedge clk);
      #1 ack_n = 1'b0;
      repeat (5) @(posedge clk);
      #1 ack_n = 1'b1;
      busy = 1'b0;
    end
  end
endmodule : ppp_printer
`default_nettype wire

/* verification/parallel_printer_port_tb_top.sv */
// bench for the printer port: host accesses, printer model, checks
// assumes the port answers one cycle after each bus strobe
`timescale 1ns/1ps
`default_nettype none
module parallel_printer_port_tb_top;
  import ppp_pkg::*;
  logic        clk, rst_n, bus_wr, bus_rd, ack_n, busy, strobe_n, restart_n, ack_irq;
  logic [23:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, out_data;
  logic [4:0]  st_in;
  int          bad_count = 0;
  int          cmp_count = 0;

  ppp_port i_ppp_port (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .out_data(out_data),
    .strobe_n(strobe_n), .restart_n(restart_n), .ack_irq(ack_irq), .ack_n(ack_n), .busy(busy),
    .paper_out(st_in[0]), .online_select(st_in[1]), .fault_n(st_in[2]),
    .serial_b_line_status(st_in[3]), .serial_a_line_status(st_in[4]));
  ppp_printer i_ppp_printer (.clk(clk), .strobe_n(strobe_n), .ack_n(ack_n), .busy(busy));

  // one host access; the answer is visible when this returns
  task automatic acc(input logic [23:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = w;
    bus_rd    = !w;
    @(posedge clk);
    #1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  endtask : acc

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8

  task automatic close_out;
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    close_out;
  end

  initial
  begin
    rst_n = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 24'h000000;
    bus_wdata = 8'h00;
    st_in = 5'h0b;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    chk8({5'h00, strobe_n, restart_n, ack_irq}, 8'h06);
    acc(ADDR_DATA, 1'b1, 8'h81);
    chk8(out_data, 8'h81);
    // two pin patterns so each of the five st_in status bits is seen both ways
    for (int i = 0; i < 5; i++)
    begin
      st_in = i[0] ? 5'h14 : 5'h0b;
      repeat (4) @(posedge clk);
      acc(ADDR_DATA, 1'b0, 8'h00);
      chk8(bus_rdata, {1'b0, st_in, 2'b01});
    end
    acc(ADDR_STROBE, 1'b1, 8'h00);
    chk8({7'h00, strobe_n}, 8'h00);
    repeat (48) @(posedge clk);
    acc(ADDR_DATA, 1'b0, 8'h00);
    chk8(bus_rdata, {1'b0, st_in, 2'b11});
    chk8({7'h00, strobe_n}, 8'h00);
    acc(ADDR_STROBE, 1'b0, 8'h00);
    chk8({strobe_n, bus_rdata[6:0]}, 8'h80);
    repeat (30) @(posedge clk);
    chk8({7'h00, ack_irq}, 8'h01);
    acc(ADDR_ACK_CLR, 1'b1, 8'hff);
    chk8({7'h00, ack_irq}, 8'h01);
    acc(ADDR_ACK_CLR, 1'b0, 8'h00);
    repeat (20) @(posedge clk);
    chk8({7'h00, ack_irq}, 8'h00);
    // second character; clear read lands on the synced ack edge, set must win
    acc(ADDR_DATA, 1'b0, 8'h00);
    chk8(bus_rdata, {1'b0, st_in, 2'b01});
    acc(ADDR_DATA, 1'b1, 8'h3c);
    chk8(out_data, 8'h3c);
    acc(ADDR_STROBE, 1'b1, 8'h00);
    repeat (50) @(posedge clk);
    acc(ADDR_STROBE, 1'b0, 8'h00);
    repeat (11) @(posedge clk);
    acc(ADDR_ACK_CLR, 1'b0, 8'h00);
    chk8({7'h00, ack_irq}, 8'h01);
    acc(ADDR_ACK_CLR, 1'b0, 8'h00);
    chk8({7'h00, ack_irq}, 8'h00);
    acc(ADDR_RESTART, 1'b1, 8'h00);
    chk8({7'h00, restart_n}, 8'h00);
    acc(ADDR_RESTART, 1'b0, 8'h00);
    chk8({7'h00, restart_n}, 8'h01);
    // board reset with both outputs on: latch must survive
    acc(ADDR_STROBE, 1'b1, 8'h00);
    acc(ADDR_RESTART, 1'b1, 8'h00);
    chk8({6'h00, strobe_n, restart_n}, 8'h00);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk8({5'h00, strobe_n, restart_n, 1'b0}, 8'h06);
    chk8(out_data, 8'h3c);
    rst_n = 1'b1;
    close_out;
  end
endmodule : parallel_printer_port_tb_top
`default_nettype wire
